// file: core/sps_status_srq.sv
// Status, service request, error flags, end-marker control and user store of the remote command interpreter.
// Assumes a byte stream of commands in ref_clk, other command logic reporting its own errors, and a talk path.
`timescale 1ns/10ps
`include "sps_consts.svh"

// Function
// RULE1: mask argument is decimal sum of weights
// RULE2: mask zero-zero never requests service
// RULE3: mask bit zero suppresses that condition
// RULE4: bits: error, overrange, underrange, operation complete
// RULE5: query argument selects machine, error, revision
// RULE6: selected word sent at next talk
// RULE7: controller should read soon after query
// RULE8: any error sets flag, maybe requests
// RULE9: error query returns flags to good; the code returns the self-test flag to fail instead
// RULE10: unknown command flagged, not executed
// RULE11: illegal option flagged, else good flag
// RULE12: self-test flag fails until passing test
// RULE13: test command runs test, stores result
// RULE14: unwritten store gives identification only
// RULE15: end marker only on final byte
// RULE16: six volatile user bytes stored
// RULE17: user bytes included in revision word
// RULE18: bit six set while requesting service
module sps_status_srq #(
	parameter logic [47:0] ID_STRING = 48'h2d_30_30_30_30_2d, // Arbitrary neutral value
	parameter int STORE_BYTES = 6
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Command byte stream
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	output logic cmd_ready,
	// Reports from the other command logic
	input wire logic foreign_bad_cmd,
	input wire logic foreign_bad_opt,
	// Measurement condition events
	input wire logic overrange_evt,
	input wire logic underrange_evt,
	input wire logic op_complete_evt,
	// Self-test engine
	output logic self_test_start,
	input wire logic self_test_done,
	input wire logic self_test_ok,
	// Talk path
	input wire logic talk_req,
	output logic status_claim,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	output logic tx_end_mark,
	input wire logic tx_ready,
	// Serial poll
	input wire logic serial_poll,
	output logic [7:0] poll_byte,
	output logic srq,
	// Indicators
	output logic good_command_ind,
	output logic bad_command_ind,
	output logic good_option_ind,
	output logic bad_option_ind,
	output logic self_test_passed_ind,
	output logic self_test_failed_ind,
	output logic end_marker_en
);
	// Store layout and revision word are built for exactly six bytes
	if (STORE_BYTES != 6)
	begin : g_bad_store
		$error("store width fixed at six bytes");
	end

	sps_pkg::sps_parse_t p_state_ff;
	sps_pkg::sps_parse_t nxt_p_state;
	sps_pkg::sps_tx_t t_state_ff;
	sps_pkg::sps_tx_t nxt_t_state;

	logic [7:0] cmd_ff;
	logic [2:0] need_ff;
	logic [2:0] cnt_ff;
	logic [7:0] arg_ff [0:5];
	logic [7:0] mask_ff;
	logic eoi_en_ff;
	logic bad_cmd_ff;
	logic bad_opt_ff;
	logic st_pass_ff;
	logic st_run_ff;
	logic st_start_ff;
	logic err_flag_ff;
	logic ovr_flag_ff;
	logic und_flag_ff;
	logic opc_flag_ff;
	logic rqs_ff;
	logic user_valid_ff;
	logic [47:0] user_ff;
	logic pend_ff;
	logic [1:0] resp_sel_ff;
	logic [2:0] resp_err_ff;
	logic [3:0] idx_ff;
	logic [7:0] tx_byte_ff;
	logic tx_last_ff;
	logic tx_multi_ff;

	// Case folding so lower-case commands work
	wire is_lower = (cmd_byte >= `SPS_CH_A_LO) && (cmd_byte <= `SPS_CH_Z_LO);
	wire [7:0] up = is_lower ? (cmd_byte - `SPS_CASE_OFS) : cmd_byte;
	wire take = cmd_valid && cmd_ready;

	// Letters owned here; everything else belongs to the other command logic
	wire is_mask_l = (up == `SPS_CH_MASK);
	wire is_query_l = (up == `SPS_CH_QUERY);
	wire is_test_l = (up == `SPS_CH_TEST);
	wire is_end_l = (up == `SPS_CH_END);
	wire is_store_l = (up == `SPS_CH_STORE);
	wire own_letter = is_mask_l || is_query_l || is_test_l || is_end_l || is_store_l;
	wire [2:0] need_cnt = is_mask_l ? `SPS_ARGS_MASK : (is_store_l ? `SPS_ARGS_STORE : `SPS_ARGS_ONE);

	// Argument decoding at execution
	wire exec = (p_state_ff == sps_pkg::SPS_P_EXEC);
	wire d1_ok = (arg_ff[0] >= `SPS_CH_0) && (arg_ff[0] <= `SPS_CH_9);
	wire d0_ok = (arg_ff[1] >= `SPS_CH_0) && (arg_ff[1] <= `SPS_CH_9);
	wire [7:0] d1 = arg_ff[0] - `SPS_CH_0;
	wire [7:0] d0 = arg_ff[1] - `SPS_CH_0;
	wire [7:0] mask_val = 8'((d1 << 3) + (d1 << 1) + d0);
	wire q_ok = (arg_ff[0] >= `SPS_CH_0) && (arg_ff[0] <= `SPS_CH_2);
	wire k_yes = (arg_ff[0] == `SPS_CH_Y);
	wire k_no = (arg_ff[0] == `SPS_CH_N);
	wire x_mask = exec && (cmd_ff == `SPS_CH_MASK);
	wire x_query = exec && (cmd_ff == `SPS_CH_QUERY);
	wire x_test = exec && (cmd_ff == `SPS_CH_TEST);
	wire x_end = exec && (cmd_ff == `SPS_CH_END);
	wire x_store = exec && (cmd_ff == `SPS_CH_STORE);
	wire ok_mask = x_mask && d1_ok && d0_ok;
	wire ok_query = x_query && q_ok;
	wire ok_test = x_test && (arg_ff[0] == `SPS_CH_0);
	wire ok_end = x_end && (k_yes || k_no);
	wire own_bad_opt = (x_mask && !(d1_ok && d0_ok)) || (x_query && !q_ok) ||
		(x_test && (arg_ff[0] != `SPS_CH_0)) || (x_end && !(k_yes || k_no));
	wire err_query = ok_query && (arg_ff[0] == `SPS_CH_0 + 8'h01);

	// Error sources
	wire opt_evt = own_bad_opt || foreign_bad_opt;
	wire st_fail_evt = st_run_ff && self_test_done && !self_test_ok;
	wire st_pass_evt = st_run_ff && self_test_done && self_test_ok;
	wire err_evt = foreign_bad_cmd || opt_evt || st_fail_evt;

	// Service request from masked conditions
	wire req_evt = (err_evt && mask_ff[`SPS_BIT_ERR]) || (overrange_evt && mask_ff[`SPS_BIT_OVR]) ||
		(underrange_evt && mask_ff[`SPS_BIT_UND]) || (op_complete_evt && mask_ff[`SPS_BIT_OPC]); // RULE2 RULE3 RULE4

	// Parser
	assign cmd_ready = (p_state_ff != sps_pkg::SPS_P_EXEC);

	always_comb
	begin
		nxt_p_state = p_state_ff;
		case (p_state_ff)
			sps_pkg::SPS_P_IDLE:
			begin
				if (take && own_letter)
					nxt_p_state = sps_pkg::SPS_P_ARG;
			end
			sps_pkg::SPS_P_ARG:
			begin
				if (take && (cnt_ff == need_ff - 3'd1))
					nxt_p_state = sps_pkg::SPS_P_EXEC;
			end
			sps_pkg::SPS_P_EXEC:
				nxt_p_state = sps_pkg::SPS_P_IDLE;
			default:
				nxt_p_state = sps_pkg::SPS_P_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			p_state_ff <= sps_pkg::SPS_P_IDLE;
			cmd_ff <= 8'h00;
			need_ff <= 3'd0;
			cnt_ff <= 3'd0;
		end
		else
		begin
			p_state_ff <= nxt_p_state;
			if (p_state_ff == sps_pkg::SPS_P_IDLE && take && own_letter)
			begin
				cmd_ff <= up;
				need_ff <= need_cnt;
				cnt_ff <= 3'd0;
			end
			else if (p_state_ff == sps_pkg::SPS_P_ARG && take)
				cnt_ff <= cnt_ff + 3'd1;
		end
	end

	// Argument bytes; store bytes keep their case
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_arg
			always_ff @(posedge ref_clk)
			begin
				if (srst)
					arg_ff[gi] <= 8'h00;
				else if (p_state_ff == sps_pkg::SPS_P_ARG && take && cnt_ff == 3'(gi))
					arg_ff[gi] <= (cmd_ff == `SPS_CH_STORE) ? cmd_byte : up;
			end
		end
	endgenerate

	// Configuration written by commands
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			mask_ff <= `SPS_MASK_RST;
			eoi_en_ff <= 1'b1;
			user_valid_ff <= 1'b0;
			user_ff <= 48'h0;
		end
		else
		begin
			if (ok_mask)
				mask_ff <= mask_val; // RULE1
			if (ok_end)
				eoi_en_ff <= k_yes; // RULE15
			if (x_store)
			begin
				user_valid_ff <= 1'b1; // RULE16
				user_ff <= {arg_ff[0], arg_ff[1], arg_ff[2], arg_ff[3], arg_ff[4], arg_ff[5]};
			end
		end
	end

	// Error and self-test flags; a new error wins over the clearing query
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bad_cmd_ff <= 1'b0;
			bad_opt_ff <= 1'b0;
			st_pass_ff <= 1'b0;
			st_run_ff <= 1'b0;
			st_start_ff <= 1'b0;
		end
		else
		begin
			st_start_ff <= ok_test; // RULE13
			if (foreign_bad_cmd)
				bad_cmd_ff <= 1'b1; // RULE10
			else if (err_query)
				bad_cmd_ff <= 1'b0; // RULE9
			if (opt_evt)
				bad_opt_ff <= 1'b1; // RULE11
			else if (err_query)
				bad_opt_ff <= 1'b0; // RULE9
			if (ok_test)
				st_run_ff <= 1'b1;
			else if (self_test_done)
				st_run_ff <= 1'b0;
			// Pass only from a commanded test; an error query returns it to the default fail
			if (st_pass_evt)
				st_pass_ff <= 1'b1; // RULE12
			else if (st_fail_evt || err_query || ok_test)
				st_pass_ff <= 1'b0; // RULE13
		end
	end

	// Serial poll byte and service request
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			err_flag_ff <= 1'b0;
			ovr_flag_ff <= 1'b0;
			und_flag_ff <= 1'b0;
			opc_flag_ff <= 1'b0;
			rqs_ff <= 1'b0;
		end
		else
		begin
			if (err_evt)
				err_flag_ff <= 1'b1; // RULE8
			else if (serial_poll || err_query)
				err_flag_ff <= 1'b0;
			if (overrange_evt)
				ovr_flag_ff <= 1'b1;
			else if (serial_poll)
				ovr_flag_ff <= 1'b0;
			if (underrange_evt)
				und_flag_ff <= 1'b1;
			else if (serial_poll)
				und_flag_ff <= 1'b0;
			if (op_complete_evt)
				opc_flag_ff <= 1'b1;
			else if (serial_poll)
				opc_flag_ff <= 1'b0;
			if (req_evt)
				rqs_ff <= 1'b1; // RULE8 RULE18
			else if (serial_poll)
				rqs_ff <= 1'b0; // RULE18
		end
	end

	// Query selection; error flags are captured as the query clears them
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pend_ff <= 1'b0;
			resp_sel_ff <= 2'b00;
			resp_err_ff <= 3'b000;
		end
		else
		begin
			if (ok_query)
			begin
				pend_ff <= 1'b1; // RULE6
				resp_sel_ff <= arg_ff[0][1:0]; // RULE5
				if (err_query)
					resp_err_ff <= {bad_cmd_ff, bad_opt_ff, st_pass_ff};
			end
			else if (t_state_ff == sps_pkg::SPS_T_DONE)
				pend_ff <= 1'b0;
		end
	end

	// Talk path: the status word replaces the measurement once
	wire [3:0] gen_idx = (t_state_ff == sps_pkg::SPS_T_IDLE) ? 4'd0 : (idx_ff + 4'd1);
	wire [7:0] gen_byte;
	wire [3:0] gen_len;
	wire start_tx = (t_state_ff == sps_pkg::SPS_T_IDLE) && talk_req && pend_ff; // RULE6
	wire adv = (t_state_ff == sps_pkg::SPS_T_SEND) && tx_ready;

	sps_word_gen #(
		.ID_STRING(ID_STRING)
	) u_word (
		.word_sel(resp_sel_ff),
		.byte_idx(gen_idx),
		.mask(mask_ff),
		.eoi_en(eoi_en_ff),
		.bad_cmd(resp_err_ff[2]),
		.bad_opt(resp_err_ff[1]),
		.st_pass(resp_err_ff[0]),
		.user_valid(user_valid_ff), // RULE14 RULE17
		.user_bytes(user_ff),
		.word_byte(gen_byte),
		.word_len(gen_len)
	);

	always_comb
	begin
		nxt_t_state = t_state_ff;
		case (t_state_ff)
			sps_pkg::SPS_T_IDLE:
			begin
				if (start_tx)
					nxt_t_state = sps_pkg::SPS_T_SEND;
			end
			sps_pkg::SPS_T_SEND:
			begin
				if (adv && tx_last_ff)
					nxt_t_state = sps_pkg::SPS_T_DONE;
			end
			sps_pkg::SPS_T_DONE:
				nxt_t_state = sps_pkg::SPS_T_IDLE;
			default:
				nxt_t_state = sps_pkg::SPS_T_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			t_state_ff <= sps_pkg::SPS_T_IDLE;
			idx_ff <= 4'd0;
			tx_byte_ff <= 8'h00;
			tx_last_ff <= 1'b0;
			tx_multi_ff <= 1'b0;
		end
		else
		begin
			t_state_ff <= nxt_t_state;
			if (start_tx)
			begin
				idx_ff <= 4'd0;
				tx_byte_ff <= gen_byte;
				tx_last_ff <= (gen_len == 4'd1);
				tx_multi_ff <= (gen_len > 4'd1);
			end
			else if (adv && !tx_last_ff)
			begin
				idx_ff <= gen_idx;
				tx_byte_ff <= gen_byte;
				tx_last_ff <= (gen_idx == gen_len - 4'd1);
			end
		end
	end

	// Outputs
	assign self_test_start = st_start_ff;
	assign status_claim = pend_ff;
	assign tx_valid = (t_state_ff == sps_pkg::SPS_T_SEND);
	assign tx_byte = tx_byte_ff;
	assign tx_end_mark = tx_valid && tx_last_ff && tx_multi_ff && eoi_en_ff; // RULE15
	assign poll_byte = {1'b0, rqs_ff, 2'b00, opc_flag_ff, und_flag_ff, ovr_flag_ff, err_flag_ff}; // RULE4 RULE18
	assign srq = rqs_ff;
	assign good_command_ind = !bad_cmd_ff; // RULE10
	assign bad_command_ind = bad_cmd_ff;
	assign good_option_ind = !bad_opt_ff; // RULE11
	assign bad_option_ind = bad_opt_ff;
	assign self_test_passed_ind = st_pass_ff;
	assign self_test_failed_ind = !st_pass_ff; // RULE12
	assign end_marker_en = eoi_en_ff;
endmodule // sps_status_srq

// file: core/sps_consts.svh
// Offsets, field positions, reset values and character codes for the status/service-request block.
// Assumes inclusion by bare name from the design files.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// Service request mask and serial poll status byte bit positions
`define SPS_BIT_ERR 3'd0
`define SPS_BIT_OVR 3'd1
`define SPS_BIT_UND 3'd2
`define SPS_BIT_OPC 3'd3
`define SPS_BIT_RQS 3'd6
`define SPS_MASK_RST 8'h00
`define SPS_MASK_USED 8'h0f

// Command letters (upper case)
`define SPS_CH_MASK 8'h4d
`define SPS_CH_QUERY 8'h55
`define SPS_CH_TEST 8'h4a
`define SPS_CH_END 8'h4b
`define SPS_CH_STORE 8'h57

// Argument characters
`define SPS_CH_0 8'h30
`define SPS_CH_2 8'h32
`define SPS_CH_9 8'h39
`define SPS_CH_Y 8'h59
`define SPS_CH_N 8'h4e
`define SPS_CH_A_LO 8'h61
`define SPS_CH_Z_LO 8'h7a
`define SPS_CASE_OFS 8'h20

// Argument counts per command
`define SPS_ARGS_MASK 3'd2
`define SPS_ARGS_ONE 3'd1
`define SPS_ARGS_STORE 3'd6

// Response lengths in bytes
`define SPS_LEN_MACHINE 4'd4
`define SPS_LEN_ERROR 4'd8
`define SPS_LEN_ID 4'd6
`define SPS_LEN_REV 4'd12

`endif

// file: core/sps_pkg.sv
// Types shared by the status/service-request block.
// Assumes nothing beyond a SystemVerilog compiler.
package sps_pkg;
	typedef enum logic [1:0]
	{
		SPS_P_IDLE = 2'b00,
		SPS_P_ARG = 2'b01,
		SPS_P_EXEC = 2'b11
	} sps_parse_t;

	typedef enum logic [1:0]
	{
		SPS_T_IDLE = 2'b00,
		SPS_T_SEND = 2'b01,
		SPS_T_DONE = 2'b11
	} sps_tx_t;

	typedef enum logic [1:0]
	{
		SPS_W_MACHINE = 2'b00,
		SPS_W_ERROR = 2'b01,
		SPS_W_REVISION = 2'b10
	} sps_word_t;
endpackage

// file: core/sps_word_gen.sv
// Byte generator for the three status words, indexed by byte position.
// Assumes the caller holds the selected fields stable while a word is sent.
`timescale 1ns/10ps
`include "sps_consts.svh"

module sps_word_gen #(
	parameter logic [47:0] ID_STRING = 48'h2d_30_30_30_30_2d // Arbitrary neutral value
)
(
	// Selection
	input wire logic [1:0] word_sel,
	input wire logic [3:0] byte_idx,
	// Fields
	input wire logic [7:0] mask,
	input wire logic eoi_en,
	input wire logic bad_cmd,
	input wire logic bad_opt,
	input wire logic st_pass,
	input wire logic user_valid,
	input wire logic [47:0] user_bytes,
	// Result
	output logic [7:0] word_byte,
	output logic [3:0] word_len
);
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
	endfunction

	logic [63:0] mach_str;
	logic [63:0] err_str;
	logic [95:0] rev_str;
	wire [3:0] ri = byte_idx;

	always_comb
	begin
		mach_str = {8'h4d, hex_char(mask[7:4]), hex_char(mask[3:0]), eoi_en ? `SPS_CH_Y : `SPS_CH_N, 32'h0};
		err_str = {bad_cmd ? 24'h49_43_4d : 24'h56_43_4d, bad_opt ? 24'h49_43_4f : 24'h56_43_4f,
			st_pass ? 16'h50_53 : 16'h46_4c};
		rev_str = {ID_STRING, user_bytes};
		case (sps_pkg::sps_word_t'(word_sel))
			sps_pkg::SPS_W_MACHINE:
			begin
				word_len = `SPS_LEN_MACHINE;
				word_byte = mach_str[8'd63 - {1'b0, ri, 3'd0} -: 8];
			end
			sps_pkg::SPS_W_ERROR:
			begin
				word_len = `SPS_LEN_ERROR;
				word_byte = err_str[8'd63 - {1'b0, ri, 3'd0} -: 8];
			end
			default:
			begin
				word_len = user_valid ? `SPS_LEN_REV : `SPS_LEN_ID;
				word_byte = rev_str[8'd95 - {1'b0, ri, 3'd0} -: 8];
			end
		endcase
	end
endmodule // sps_word_gen

// file: tb/sps_monitor.sv
// Assertion checker for the status and service request block.
// Assumes it is bound into sps_status_srq and sees only its ports.
`timescale 1ns/10ps
module sps_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Inputs seen
	input wire logic foreign_bad_cmd,
	input wire logic overrange_evt,
	input wire logic tx_ready,
	input wire logic serial_poll,
	input wire logic foreign_bad_opt,
	input wire logic underrange_evt,
	input wire logic op_complete_evt,
	input wire logic self_test_done,
	// Outputs watched
	input wire logic cmd_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_end_mark,
	input wire logic end_marker_en,
	input wire logic self_test_start,
	input wire logic [7:0] poll_byte,
	input wire logic srq,
	input wire logic good_command_ind,
	input wire logic bad_command_ind,
	input wire logic self_test_passed_ind,
	input wire logic self_test_failed_ind
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_rqs_bit; srq == poll_byte[6]; endproperty
	a_rqs_bit: assert property (p_rqs_bit) else $error("srq differs from poll bit six");
	property p_unused; poll_byte[7] == 1'b0 && poll_byte[5:4] == 2'b00; endproperty
	a_unused: assert property (p_unused) else $error("unused poll bits set");
	property p_cmd_ind; good_command_ind != bad_command_ind; endproperty
	a_cmd_ind: assert property (p_cmd_ind) else $error("command indicators not complementary");
	property p_st_ind; self_test_passed_ind != self_test_failed_ind; endproperty
	a_st_ind: assert property (p_st_ind) else $error("self-test indicators not complementary");
	property p_bad_cmd; foreign_bad_cmd |-> ##[1:2] bad_command_ind && poll_byte[0]; endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not flagged");
	property p_ovr; overrange_evt |=> poll_byte[1]; endproperty
	a_ovr: assert property (p_ovr) else $error("overrange not in poll byte");
	property p_eoi; tx_end_mark |-> tx_valid && end_marker_en; endproperty
	a_eoi: assert property (p_eoi) else $error("end mark without enabled byte");
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
	a_hold: assert property (p_hold) else $error("reply byte dropped while stalled");
	property p_start; self_test_start |=> !self_test_start; endproperty
	a_start: assert property (p_start) else $error("self-test start longer than a pulse");
	// A quiet poll must leave nothing pending; an event in the same cycle would win
	property p_poll_clr;
		serial_poll && cmd_ready && !self_test_done && !foreign_bad_cmd && !foreign_bad_opt &&
			!overrange_evt && !underrange_evt && !op_complete_evt |=> !srq && poll_byte == 8'h00;
	endproperty
	a_poll_clr: assert property (p_poll_clr) else $error("poll did not clear service request");
endmodule // sps_monitor

// file: tb/sps_ctrl_model.sv
// Bus controller model: sends commands, addresses the block to talk, polls, answers self-tests.
// Assumes one ref_clk; all outputs change 1 ns after a rising edge.
`timescale 1ns/10ps
module sps_ctrl_model (
	// Clock
	input wire logic ref_clk,
	// Command stream
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	input wire logic cmd_ready,
	// Talk and poll
	output logic talk_req,
	output logic tx_ready,
	output logic serial_poll,
	input wire logic status_claim,
	// Self-test engine
	input wire logic self_test_start,
	output logic self_test_done,
	output logic self_test_ok
);
	int seed = 32'hc8ec;
	logic st_ok = 1'b1;
	logic [2:0] st_cnt = 3'h0;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		talk_req = 1'b0;
		tx_ready = 1'b0;
		serial_poll = 1'b0;
		self_test_done = 1'b0;
		self_test_ok = 1'b0;
	end
	// Random stalls on the reply path
	always @(posedge ref_clk)
	begin
		tx_ready <= #1 ($random(seed) & 3) != 0;
		self_test_done <= #1 (st_cnt == 3'h1);
		self_test_ok <= #1 st_ok;
		if (self_test_start === 1'b1)
			st_cnt <= 3'h5;
		else if (st_cnt != 3'h0)
			st_cnt <= st_cnt - 3'h1;
	end
	task automatic send(input string s);
		foreach (s[i])
		begin
			cmd_byte = s[i];
			cmd_valid = 1'b1;
			@(negedge ref_clk);
			while (!cmd_ready) @(negedge ref_clk);
			@(posedge ref_clk);
			#1;
		end
		cmd_valid = 1'b0;
		// Released bus shows no stale byte
		cmd_byte = ~cmd_byte;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic talk();
		talk_req = 1'b1;
		@(posedge ref_clk);
		#1;
		talk_req = 1'b0;
		for (int i = 0; i < 200 && status_claim === 1'b1; i++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic poll();
		serial_poll = 1'b1;
		@(posedge ref_clk);
		#1;
		serial_poll = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
endmodule // sps_ctrl_model

// file: tb/tb_top.sv
// Self-checking bench for the status and service request block.
// Assumes the controller model in sps_ctrl_model and the checker in sps_monitor.
`timescale 1ns/10ps
module tb_top;
	logic ref_clk, srst, foreign_bad_cmd, foreign_bad_opt, overrange_evt, underrange_evt, op_complete_evt;
	logic cmd_valid, cmd_ready, talk_req, status_claim, tx_valid, tx_end_mark, tx_ready, serial_poll, srq;
	logic self_test_start, self_test_done, self_test_ok, end_marker_en, good_command_ind, bad_command_ind;
	logic good_option_ind, bad_option_ind, self_test_passed_ind, self_test_failed_ind;
	logic [7:0] cmd_byte, tx_byte, poll_byte;
	logic [4:0] evts;
	logic [8:0] exp_q[$];
	logic eoi_on = 1'b1;
	string wdat = "abcdef";
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	assign {op_complete_evt, underrange_evt, overrange_evt, foreign_bad_opt, foreign_bad_cmd} = evts;
	sps_status_srq dut (.ref_clk, .srst, .cmd_valid, .cmd_byte, .cmd_ready, .foreign_bad_cmd, .foreign_bad_opt,
		.overrange_evt, .underrange_evt, .op_complete_evt, .self_test_start, .self_test_done, .self_test_ok,
		.talk_req, .status_claim, .tx_valid, .tx_byte, .tx_end_mark, .tx_ready, .serial_poll, .poll_byte, .srq,
		.good_command_ind, .bad_command_ind, .good_option_ind, .bad_option_ind, .self_test_passed_ind,
		.self_test_failed_ind, .end_marker_en);
	sps_ctrl_model ctl (.ref_clk, .cmd_valid, .cmd_byte, .cmd_ready, .talk_req, .tx_ready, .serial_poll,
		.status_claim, .self_test_start, .self_test_done, .self_test_ok);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic query(input string c, input string w);
		foreach (w[i]) exp_q.push_back({eoi_on && i == w.len() - 1, w[i]});
		ctl.send({"U", c});
		ctl.talk();
		check("pending bytes", 9'(exp_q.size()), 0);
	endtask
	task automatic ev(input logic [4:0] v);
		evts = v;
		@(posedge ref_clk);
		#1;
		evts = 5'h00;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	// Reply watcher takes the oldest note for each accepted byte
	always @(posedge ref_clk)
		if (!srst && tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("extra byte", {tx_end_mark, tx_byte}, 9'h1ff);
			else
				check("reply byte", {tx_end_mark, tx_byte}, exp_q.pop_front());
		end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			conclude();
		end
	end
	initial
	begin
		srst = 1'b1;
		evts = 5'h00;
		repeat (8) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		@(posedge ref_clk);
		#1;
		check("reset inds", {good_command_ind, self_test_failed_ind, end_marker_en}, 3'h7);
		check("reset poll", {srq, poll_byte}, 0);
		query("2", "-0000-");
		query("0", "M00Y");
		$display("test reset and words done");
		ctl.send("m12");
		ev(5'h04);
		check("ovr masked", {srq, poll_byte}, 9'h002);
		ev(5'h08);
		check("und request", {srq, poll_byte}, 9'h146);
		ctl.poll();
		check("poll clear", {srq, poll_byte}, 0);
		ev(5'h10);
		check("opc request", {srq, poll_byte}, 9'h148);
		ctl.poll();
		check("opc poll clear", {srq, poll_byte}, 0);
		ctl.send("M00");
		ev(5'h01);
		check("err masked", {srq, bad_command_ind, poll_byte[0]}, 3'b011);
		ctl.send("U5");
		check("bad option", {bad_option_ind, good_option_ind}, 2'b10);
		ctl.send("M01");
		ev(5'h02);
		check("err request", srq, 1);
		ctl.poll();
		$display("test mask done");
		query("1", "ICMICOFL");
		query("1", "VCMVCOFL");
		check("flags clear", {bad_command_ind, bad_option_ind, poll_byte}, 0);
		ctl.send("J0");
		repeat (12) @(posedge ref_clk);
		#1;
		check("test pass", {self_test_passed_ind, srq}, 2'b10);
		query("1", "VCMVCOPS");
		ctl.st_ok = 1'b0;
		ctl.send("j0");
		repeat (12) @(posedge ref_clk);
		#1;
		check("test fail", {self_test_failed_ind, srq, poll_byte[0]}, 3'b111);
		query("1", "VCMVCOFL");
		ctl.poll();
		$display("test self-test done");
		ctl.send("KN");
		eoi_on = 1'b0;
		query("0", "M01N");
		ctl.send("kY");
		eoi_on = 1'b1;
		for (int i = 0; i < 6; i++) wdat[i] = 8'h41 + 8'($unsigned($random(ctl.seed)) % 26);
		ctl.send({"W", wdat});
		query("2", {"-0000-", wdat});
		$display("test end mark and store done");
		conclude();
	end
endmodule // tb_top
bind sps_status_srq sps_monitor mon (.ref_clk, .srst, .foreign_bad_cmd, .overrange_evt, .tx_ready, .serial_poll,
	.foreign_bad_opt, .underrange_evt, .op_complete_evt, .self_test_done, .cmd_ready, .tx_valid,
	.tx_byte, .tx_end_mark, .end_marker_en, .self_test_start, .poll_byte, .srq, .good_command_ind,
	.bad_command_ind, .self_test_passed_ind, .self_test_failed_ind);
